// >>> src/csg_clk_div.sv
`timescale 1ns/10ps
`default_nettype none
module csg_clk_div #(
    parameter int HALF = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic gate_in,
    input wire logic force_low_in,
    output logic clk_out,
    output logic fall_out
);
    // ------------------------------------------------------------
    // phase counter and gate
    // ------------------------------------------------------------
    localparam int W = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [W-1:0] LAST = W'(HALF - 1);
    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic phase_q;
    logic phase_d;
    logic en_q;
    logic en_d;
    logic clk_d;
    wire wrap = (cnt_q == LAST);
    wire step = run_in & wrap;

    // counter freezes while the oscillator is off
    assign cnt_d = !run_in ? cnt_q : (wrap ? '0 : cnt_q + ONE);
    assign phase_d = phase_q ^ step;
    // gate only changes at the low-to-high point: stops low, restarts full high
    assign en_d = force_low_in ? 1'b0 : ((step & ~phase_q) ? ~gate_in : en_q);
    assign clk_d = phase_d & en_d & ~force_low_in;
    assign fall_out = step & phase_q;

    // state registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            phase_q <= 1'b0;
            en_q <= 1'b0;
            clk_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            en_q <= en_d;
            clk_out <= clk_d;
        end
    end
endmodule
`default_nettype wire

// >>> src/csg_clock_gate.sv
`timescale 1ns/10ps
`default_nettype none
module csg_clock_gate #(
    parameter int PCI_N = 4,
    parameter int SDR_N = 13,
    parameter int LOCK_CYC = csg_pkg::PWRUP_LAT_CYC,
    parameter int POR_CYC = csg_pkg::POR_CYC,
    parameter int HOLD_CYC = csg_pkg::PD_HOLD_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic proc_stop_n_in,
    input wire logic pci_stop_n_in,
    input wire logic sdram_stop_n_in,
    input wire logic power_down_n_in,
    input wire logic [csg_pkg::STRAP_W-1:0] strap_pin_in,
    output logic [csg_pkg::STRAP_W-1:0] strap_pin_out,
    output logic [csg_pkg::STRAP_W-1:0] strap_pin_oe_n_out,
    output logic [csg_pkg::STRAP_W-1:0] strap_value_out,
    output logic proc_clk_out,
    output logic [PCI_N-1:0] pci_clk_out,
    output logic [SDR_N-1:0] sdram_clk_out,
    output logic osc_enable_out,
    output logic power_down_out
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [csg_pkg::CNT_W-1:0] POR_LAST = csg_pkg::CNT_W'(POR_CYC - 1);
    localparam logic [csg_pkg::CNT_W-1:0] HOLD_LAST = csg_pkg::CNT_W'(HOLD_CYC - 1);
    localparam logic [csg_pkg::CNT_W-1:0] LOCK_LAST = csg_pkg::CNT_W'(LOCK_CYC - 1);
    localparam logic [csg_pkg::CNT_W-1:0] CNT_ONE = csg_pkg::CNT_W'(1);

    csg_pkg::csg_state_e state_q;
    csg_pkg::csg_state_e state_d;
    logic [csg_pkg::SYN_W-1:0] sync1_q;
    logic [csg_pkg::SYN_W-1:0] sync2_q;
    logic [csg_pkg::CNT_W-1:0] cnt_q;
    logic [csg_pkg::CNT_W-1:0] cnt_d;
    logic [csg_pkg::STRAP_W-1:0] strap_q;
    logic [csg_pkg::STRAP_W-1:0] strap_d;
    logic strap_done_q;
    logic strap_done_d;
    logic force_q;
    logic force_d;
    logic osc_q;
    logic osc_d;
    logic pd_q;
    logic pd_d;
    logic proc_clk;
    logic pci_clk;
    logic pci_free_clk;
    logic sdr_clk;
    logic ref_clk;
    logic usb_clk;
    logic proc_fall;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // two flops per lane; only the second stage feeds any logic
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= csg_pkg::SYN_RST;
            sync2_q <= csg_pkg::SYN_RST;
        end else begin
            sync1_q <= {power_down_n_in, sdram_stop_n_in, pci_stop_n_in, proc_stop_n_in};
            sync2_q <= sync1_q;
        end
    end

    // synchronised, active-high request levels
    wire proc_stop = ~sync2_q[csg_pkg::SYN_PROC];
    wire pci_stop = ~sync2_q[csg_pkg::SYN_PCI];
    wire sdr_stop = ~sync2_q[csg_pkg::SYN_SDR];
    wire pd_req = ~sync2_q[csg_pkg::SYN_PD];

    // ------------------------------------------------------------
    // state decode
    // ------------------------------------------------------------
    wire st_strap = (state_q == csg_pkg::CSG_ST_STRAP);
    wire st_run = (state_q == csg_pkg::CSG_ST_RUN);
    wire st_drain = (state_q == csg_pkg::CSG_ST_DRAIN);
    wire st_hold = (state_q == csg_pkg::CSG_ST_HOLD);
    wire st_off = (state_q == csg_pkg::CSG_ST_OFF);
    wire st_wake = (state_q == csg_pkg::CSG_ST_WAKE);
    wire pd_active = st_drain | st_hold | st_off | st_wake;
    wire all_low = ~(proc_clk | pci_clk | pci_free_clk | sdr_clk | ref_clk | usb_clk);
    wire por_done = st_strap & (cnt_q == POR_LAST);
    wire hold_done = st_hold & all_low & (cnt_q == HOLD_LAST);
    wire lock_done = st_wake & (cnt_q == LOCK_LAST);

    // ------------------------------------------------------------
    // gate selection
    // ------------------------------------------------------------
    // while powering down the stop levels do not matter: force wins
    wire gate_proc = proc_stop & ~pd_active;
    wire gate_pci = pci_stop & ~pd_active;
    wire gate_sdr = sdr_stop & ~pd_active;
    // reference and usb stop at their own next low point, may take a few cycles
    wire gate_slow = pd_active;
    // dividers freeze whenever the oscillator is off
    wire run_div = osc_q;

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    // one counter serves the strap window, hold and lock waits
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + CNT_ONE;
        unique case (state_q)
            csg_pkg::CSG_ST_STRAP: begin
                if (por_done) begin
                    state_d = csg_pkg::CSG_ST_RUN;
                    cnt_d = '0;
                end
            end
            csg_pkg::CSG_ST_RUN: begin
                cnt_d = '0;
                if (pd_req) begin
                    state_d = csg_pkg::CSG_ST_DRAIN;
                end
            end
            csg_pkg::CSG_ST_DRAIN: begin
                cnt_d = '0;
                if (proc_fall) begin
                    state_d = csg_pkg::CSG_ST_HOLD;
                end
            end
            csg_pkg::CSG_ST_HOLD: begin
                // restart the count if a slow clock is still high
                if (!all_low) begin
                    cnt_d = '0;
                end
                if (hold_done) begin
                    state_d = csg_pkg::CSG_ST_OFF;
                    cnt_d = '0;
                end
            end
            csg_pkg::CSG_ST_OFF: begin
                cnt_d = '0;
                if (!pd_req) begin
                    state_d = csg_pkg::CSG_ST_WAKE;
                end
            end
            csg_pkg::CSG_ST_WAKE: begin
                if (lock_done) begin
                    state_d = csg_pkg::CSG_ST_RUN;
                    cnt_d = '0;
                end
            end
            default: begin
                state_d = csg_pkg::CSG_ST_RUN;
                cnt_d = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    // strap value caught on the clock at the end of the window
    assign strap_d = por_done ? strap_pin_in : strap_q;
    assign strap_done_d = strap_done_q | por_done;
    // forced low from the processor falling edge until lock is back
    assign force_d = (st_drain & proc_fall) | st_hold | st_off | (st_wake & ~lock_done);
    // gated groups drop on the same edge as the processor clock; the processor
    // divider keeps the registered copy so its fall flag never loops back into itself
    wire force_now = force_d;
    // oscillator stops only after the hold proves every output low
    assign osc_d = ~((st_hold & hold_done) | (st_off & pd_req));
    assign pd_d = (state_d != csg_pkg::CSG_ST_STRAP) & (state_d != csg_pkg::CSG_ST_RUN);

    // sequencer registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= csg_pkg::CSG_ST_STRAP;
            cnt_q <= '0;
            strap_q <= csg_pkg::STRAP_RST;
            strap_done_q <= 1'b0;
            force_q <= 1'b0;
            osc_q <= 1'b1;
            pd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            strap_q <= strap_d;
            strap_done_q <= strap_done_d;
            force_q <= force_d;
            osc_q <= osc_d;
            pd_q <= pd_d;
        end
    end

    // ------------------------------------------------------------
    // clock generators
    // ------------------------------------------------------------
    // processor group
    csg_clk_div #(.HALF(csg_pkg::PROC_HALF)) u_proc (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run_div),
        .gate_in(gate_proc), .force_low_in(force_q),
        .clk_out(proc_clk), .fall_out(proc_fall)
    );
    // gated pci group
    csg_clk_div #(.HALF(csg_pkg::PCI_HALF)) u_pci (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run_div),
        .gate_in(gate_pci), .force_low_in(force_now),
        .clk_out(pci_clk), .fall_out()
    );
    // free-running pci copy ignores the pci stop
    csg_clk_div #(.HALF(csg_pkg::PCI_HALF)) u_pci_free (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run_div),
        .gate_in(1'b0), .force_low_in(force_now),
        .clk_out(pci_free_clk), .fall_out()
    );
    // sdram group finishes its cycle before stopping
    csg_clk_div #(.HALF(csg_pkg::SDR_HALF)) u_sdr (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run_div),
        .gate_in(gate_sdr), .force_low_in(force_now),
        .clk_out(sdr_clk), .fall_out()
    );
    // reference and usb are not forced, so a high phase is never cut
    csg_clk_div #(.HALF(csg_pkg::REF_HALF)) u_ref (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run_div),
        .gate_in(gate_slow), .force_low_in(1'b0),
        .clk_out(ref_clk), .fall_out()
    );
    csg_clk_div #(.HALF(csg_pkg::USB_HALF)) u_usb (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .run_in(run_div),
        .gate_in(gate_slow), .force_low_in(1'b0),
        .clk_out(usb_clk), .fall_out()
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // fan-out copies; all come straight from divider flops
    assign proc_clk_out = proc_clk;
    assign pci_clk_out = {PCI_N{pci_clk}};
    assign sdram_clk_out = {SDR_N{sdr_clk}};
    assign strap_pin_out[csg_pkg::PIN_REF1] = ref_clk;
    assign strap_pin_out[csg_pkg::PIN_REF0] = ref_clk;
    assign strap_pin_out[csg_pkg::PIN_PCI_FREE] = pci_free_clk;
    assign strap_pin_out[csg_pkg::PIN_PCI0] = pci_clk;
    assign strap_pin_out[csg_pkg::PIN_USB] = usb_clk;
    // pins stay released until the strap window closes
    assign strap_pin_oe_n_out = {csg_pkg::STRAP_W{~strap_done_q}};
    assign strap_value_out = strap_q;
    assign osc_enable_out = osc_q;
    assign power_down_out = pd_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_STRAP_RELEASE: assert property (
        st_strap |-> strap_pin_oe_n_out == {csg_pkg::STRAP_W{1'b1}})
        else $error("shared pins driven during strap window");

    AST_STRAP_CAPTURE: assert property (
        $rose(strap_done_q) |-> strap_value_out == $past(strap_pin_in) && strap_pin_oe_n_out == '0)
        else $error("strap latch did not take the pin levels");

    AST_PROC_OFF: assert property (
        (proc_stop && st_run) [*4] |-> !proc_clk_out)
        else $error("processor clock still running after stop");

    AST_PROC_ON: assert property (
        st_run && $fell(proc_stop) |-> ##[1:4] proc_clk_out)
        else $error("processor clock did not restart in time");

    AST_PCI_FULL_HIGH: assert property (
        $rose(pci_clk_out[0]) && st_run |=> pci_clk_out[0] || pd_active)
        else $error("pci clock high phase cut short");

    AST_PCI_FREE: assert property (
        (pci_stop && st_run) [*8] |-> ##[0:3] strap_pin_out[csg_pkg::PIN_PCI_FREE])
        else $error("free-running pci clock was gated");

    AST_SDR_STOP: assert property (
        (sdr_stop && !proc_stop && st_run) [*4] |-> !sdram_clk_out[0] && (proc_clk_out || $past(proc_clk_out)))
        else $error("sdram stop wrong or processor clock disturbed");

    AST_PD_EDGE: assert property (
        $rose(force_q) |-> $past(st_drain) && $past(proc_fall) && !proc_clk_out)
        else $error("power-down force not on processor falling edge");

    AST_PD_LOW: assert property (
        $fell(osc_enable_out) |-> $past(all_low, 1) && !proc_clk_out && !sdram_clk_out[0])
        else $error("oscillator stopped with an output high");

    AST_PD_QUIET: assert property (
        !osc_enable_out |=> $stable(strap_pin_out) && !pci_clk_out[0] && !proc_clk_out)
        else $error("clock moved while oscillator off");

    // stop and restart latencies count from the synchronised level
    AST_PCI_OFF: assert property (
        (pci_stop && st_run) [*4] |-> !pci_clk_out[0])
        else $error("pci clock still running after stop");

    AST_PCI_ON: assert property (
        st_run && $fell(pci_stop) |-> ##[1:4] pci_clk_out[0])
        else $error("pci clock did not restart in time");

    AST_SDR_ON: assert property (
        st_run && $fell(sdr_stop) |-> ##[1:2] sdram_clk_out[0])
        else $error("sdram clock did not restart in time");

    AST_PD_SYNC: assert property (
        $rose(power_down_out) |-> $past(pd_req) && $past(st_run))
        else $error("power-down entered without a synchronised request");

    COV_STRAP: cover property (st_strap ##1 st_run);
    COV_PCI_STOP: cover property (st_run && pci_stop [*4] ##1 !pci_stop);
    COV_PROC_STOP: cover property (st_run && proc_stop [*8] ##1 !proc_stop);
    COV_PD_ENTER: cover property (st_drain ##[1:4] st_hold);
    COV_WAKE: cover property (st_wake ##1 st_run);
endmodule
`default_nettype wire

// >>> src/csg_pkg.sv
package csg_pkg;
    // ------------------------------------------------------------
    // timing base
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    // strap sampling window after reset release (least time, round up)
    localparam int POR_NS = 10000;
    localparam int POR_CYC = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // oscillator restart budget, kept under the 3 ms ceiling (longest, round down)
    localparam int PWRUP_LAT_NS = 2000000;
    localparam int PWRUP_LAT_CYC = PWRUP_LAT_NS / CLK_PERIOD_NS;
    // settle time with every output low before the oscillators stop
    localparam int PD_HOLD_NS = 80;
    localparam int PD_HOLD_CYC = PD_HOLD_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 18;

    // ------------------------------------------------------------
    // half periods of each clock group, in reference cycles
    // ------------------------------------------------------------
    localparam int PROC_HALF = 1;
    localparam int PCI_HALF = 2;
    localparam int SDR_HALF = 1;
    localparam int REF_HALF = 3;
    localparam int USB_HALF = 1;

    // ------------------------------------------------------------
    // strap latch and shared pin layout
    // ------------------------------------------------------------
    localparam int STRAP_W = 5;
    localparam int PIN_REF1 = 0;
    localparam int PIN_REF0 = 1;
    localparam int PIN_PCI_FREE = 2;
    localparam int PIN_PCI0 = 3;
    localparam int PIN_USB = 4;
    localparam logic [STRAP_W-1:0] STRAP_RST = 5'h00;

    // ------------------------------------------------------------
    // synchroniser lanes, idle level high (all inputs active low)
    // ------------------------------------------------------------
    localparam int SYN_W = 4;
    localparam int SYN_PROC = 0;
    localparam int SYN_PCI = 1;
    localparam int SYN_SDR = 2;
    localparam int SYN_PD = 3;
    localparam logic [SYN_W-1:0] SYN_RST = 4'hF;

    // ------------------------------------------------------------
    // power sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSG_ST_STRAP = 3'b000,
        CSG_ST_RUN = 3'b001,
        CSG_ST_DRAIN = 3'b010,
        CSG_ST_HOLD = 3'b011,
        CSG_ST_OFF = 3'b100,
        CSG_ST_WAKE = 3'b101
    } csg_state_e;
endpackage

// >>> verification/csg_pm_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// power-management partner: stop lines, power-down, strap pulls
// ------------------------------------------------------------
module csg_pm_model #(
    // 100 processor periods of two reference cycles each
    parameter int PROC_MIN_HI = 200,
    parameter int PCI_MIN_HI = 40
) (
    input wire logic clk_in,
    input wire logic proc_req_in,
    input wire logic pci_req_in,
    input wire logic sdr_req_in,
    input wire logic pd_req_in,
    input wire logic [4:0] strap_cfg_in,
    input wire logic [4:0] strap_drive_in,
    input wire logic [4:0] strap_oe_n_in,
    output logic proc_stop_n_out,
    output logic pci_stop_n_out,
    output logic sdram_stop_n_out,
    output logic power_down_n_out,
    output logic [4:0] strap_pin_out
);
    logic proc_stop_n_q = 1'b1;
    logic pci_stop_n_q = 1'b1;
    logic sdr_stop_n_q = 1'b1;
    logic pd_n_q = 1'b1;
    logic [7:0] proc_hi_q = 8'h00;
    logic [7:0] pci_hi_q = 8'h00;

    // a processor or pci stop request waits until that clock has run its minimum enabled time
    always_ff @(posedge clk_in) begin
        proc_hi_q <= proc_stop_n_q ? ((proc_hi_q == 8'hFF) ? proc_hi_q : proc_hi_q + 8'h01) : 8'h00;
        pci_hi_q <= pci_stop_n_q ? ((pci_hi_q == 8'hFF) ? pci_hi_q : pci_hi_q + 8'h01) : 8'h00;
        if (!proc_req_in) begin
            proc_stop_n_q <= 1'b1;
        end else if (proc_hi_q >= PROC_MIN_HI) begin
            proc_stop_n_q <= 1'b0;
        end
        if (!pci_req_in) begin
            pci_stop_n_q <= 1'b1;
        end else if (pci_hi_q >= PCI_MIN_HI) begin
            pci_stop_n_q <= 1'b0;
        end
        sdr_stop_n_q <= !sdr_req_in;
        pd_n_q <= !pd_req_in;
    end

    // resistor level while the pin floats, driver level once enabled
    assign strap_pin_out = (strap_oe_n_in & strap_cfg_in) | (~strap_oe_n_in & strap_drive_in);
    assign proc_stop_n_out = proc_stop_n_q;
    assign pci_stop_n_out = pci_stop_n_q;
    assign sdram_stop_n_out = sdr_stop_n_q;
    assign power_down_n_out = pd_n_q;
endmodule
`default_nettype wire

// >>> verification/tb_csg_clock_gate.sv
`timescale 1ns/10ps
`default_nettype none
module tb_csg_clock_gate;
    localparam int PCI_N = 4;
    localparam int SDR_N = 13;
    localparam int WIN = 24;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic proc_req = 1'b0, pci_req = 1'b0, sdr_req = 1'b0, pd_req = 1'b0;
    logic [4:0] strap_cfg = 5'h00;
    wire logic proc_stop_n, pci_stop_n, sdram_stop_n, power_down_n;
    wire logic [4:0] strap_pin, pin_out, pin_oe_n, strap_value;
    wire logic proc_clk_out, osc_enable_out, power_down_out;
    wire logic [PCI_N-1:0] pci_clk_out;
    wire logic [SDR_N-1:0] sdram_clk_out;
    int n_mismatch = 0;
    int checked = 0;
    integer seed = 32'h2FD1;
    logic [31:0] rnd;
    logic [31:0] cnt [0:6];
    int hp = 0, hc = 0, hs = 0;

    always #5 clk_in = ~clk_in;

    csg_clock_gate #(.PCI_N(PCI_N), .SDR_N(SDR_N), .LOCK_CYC(20), .POR_CYC(8), .HOLD_CYC(8)) u_csg_clock_gate (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .proc_stop_n_in(proc_stop_n), .pci_stop_n_in(pci_stop_n),
        .sdram_stop_n_in(sdram_stop_n), .power_down_n_in(power_down_n), .strap_pin_in(strap_pin),
        .strap_pin_out(pin_out), .strap_pin_oe_n_out(pin_oe_n), .strap_value_out(strap_value),
        .proc_clk_out(proc_clk_out), .pci_clk_out(pci_clk_out), .sdram_clk_out(sdram_clk_out),
        .osc_enable_out(osc_enable_out), .power_down_out(power_down_out));

    csg_pm_model u_csg_pm_model (
        .clk_in(clk_in), .proc_req_in(proc_req), .pci_req_in(pci_req), .sdr_req_in(sdr_req),
        .pd_req_in(pd_req), .strap_cfg_in(strap_cfg), .strap_drive_in(pin_out), .strap_oe_n_in(pin_oe_n),
        .proc_stop_n_out(proc_stop_n), .pci_stop_n_out(pci_stop_n), .sdram_stop_n_out(sdram_stop_n),
        .power_down_n_out(power_down_n), .strap_pin_out(strap_pin));

    // ------------------------------------------------------------
    // comparison and verdict
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] exp_rises(input int half, input logic en);
        return en ? WIN / (2 * half) : 0;
    endfunction

    // ------------------------------------------------------------
    // high-phase width monitor: a runt pulse shows as a short count
    // ------------------------------------------------------------
    task automatic width_mon(inout int n, input logic v, input int half, input string what);
        if (v) begin
            n++;
        end else begin
            if (n != 0) check(n, half, what);
            n = 0;
        end
    endtask

    // forced power-down can cut a pci phase short, so skip it there
    always @(negedge clk_in) begin
        if (!rst_n_in || power_down_out) begin
            hp = 0;
            hc = 0;
            hs = 0;
        end else begin
            width_mon(hp, proc_clk_out, csg_pkg::PROC_HALF, "proc high width");
            width_mon(hc, pci_clk_out[0], csg_pkg::PCI_HALF, "pci high width");
            width_mon(hs, sdram_clk_out[0], csg_pkg::SDR_HALF, "sdram high width");
        end
    end

    // ------------------------------------------------------------
    // stimulus helpers
    // ------------------------------------------------------------
    task automatic do_reset;
        @(posedge clk_in);
        #1;
        rst_n_in = 1'b0;
        rnd = $random(seed);
        strap_cfg = rnd[4:0];
        repeat (16) @(posedge clk_in);
        #1;
        check({proc_clk_out, osc_enable_out, power_down_out, pin_oe_n}, {3'b010, 5'h1F}, "reset state");
        rst_n_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #1;
        check(pin_oe_n, 5'h1F, "pins still sampling");
        repeat (4) @(posedge clk_in);
        #1;
        check(pin_oe_n, 5'h00, "pins driving");
        check(strap_value, strap_cfg, "strap latch");
    endtask

    // the model may hold a stop back for its minimum enabled time
    task automatic apply(input logic p, input logic c, input logic s);
        int n;
        @(posedge clk_in);
        #1;
        proc_req = p;
        pci_req = c;
        sdr_req = s;
        for (n = 0; n < 300 && {proc_stop_n, pci_stop_n, sdram_stop_n} !== ~{p, c, s}; n++) begin
            @(posedge clk_in);
            #1;
        end
        repeat (7) @(posedge clk_in);
        #1;
    endtask

    task automatic count_window;
        logic [6:0] prev, cur;
        for (int k = 0; k < 7; k++) cnt[k] = 0;
        #1;
        prev = {pin_out[4], pin_out[0], pin_out[2], sdram_clk_out[0], pin_out[3], pci_clk_out[0], proc_clk_out};
        repeat (WIN) begin
            @(posedge clk_in);
            #1;
            cur = {pin_out[4], pin_out[0], pin_out[2], sdram_clk_out[0], pin_out[3], pci_clk_out[0], proc_clk_out};
            for (int k = 0; k < 7; k++) if (cur[k] && !prev[k]) cnt[k]++;
            prev = cur;
        end
    endtask

    // pe, ce, se: processor, gated pci and sdram groups expected to run
    task automatic check_run(input logic pe, input logic ce, input logic se);
        count_window();
        check(cnt[0], exp_rises(csg_pkg::PROC_HALF, pe), "proc rises");
        check(cnt[1], exp_rises(csg_pkg::PCI_HALF, ce), "pci rises");
        check(cnt[2], exp_rises(csg_pkg::PCI_HALF, ce), "shared pci rises");
        check(cnt[3], exp_rises(csg_pkg::SDR_HALF, se), "sdram rises");
        check(cnt[4], exp_rises(csg_pkg::PCI_HALF, 1'b1), "free pci rises");
        check(cnt[5], exp_rises(csg_pkg::REF_HALF, 1'b1), "ref rises");
        check(cnt[6], exp_rises(csg_pkg::USB_HALF, 1'b1), "usb rises");
        check({proc_clk_out & ~pe, pci_clk_out[0] & ~ce, sdram_clk_out[0] & ~se}, 0, "stopped low");
        check(pci_clk_out === {PCI_N{pci_clk_out[0]}}, 1, "pci copies");
        check(sdram_clk_out === {SDR_N{sdram_clk_out[0]}}, 1, "sdram copies");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        do_reset();
        check_run(1'b1, 1'b1, 1'b1);
        apply(1'b1, 1'b1, 1'b1);
        check_run(1'b0, 1'b0, 1'b0);
        apply(1'b0, 1'b0, 1'b0);
        check_run(1'b1, 1'b1, 1'b1);
        repeat (10) begin
            rnd = $random(seed);
            apply(rnd[0], rnd[1], rnd[2]);
            check_run(!rnd[0], !rnd[1], !rnd[2]);
        end
        apply(1'b0, 1'b0, 1'b0);
        // power-down entry, processor and pci stop lines toggled while down, then wake
        pd_req = 1'b1;
        for (n = 0; n < 8 && power_down_out !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        check(power_down_out, 1'b1, "power-down taken");
        repeat (3) @(posedge clk_in);
        #1;
        check({proc_clk_out, pci_clk_out, sdram_clk_out, pin_out[3:2]}, 0, "forced low");
        for (n = 0; n < 40 && osc_enable_out !== 1'b0; n++) begin
            @(posedge clk_in);
            #1;
        end
        check({osc_enable_out, proc_clk_out, pci_clk_out, sdram_clk_out, pin_out}, 0, "all low, osc off");
        apply(1'b1, 1'b1, 1'b0);
        count_window();
        for (int k = 0; k < 7; k++) check(cnt[k], 0, "clock while down");
        apply(1'b0, 1'b0, 1'b0);
        check(osc_enable_out, 1'b0, "osc still off");
        pd_req = 1'b0;
        for (n = 0; n < 40 && power_down_out !== 1'b0; n++) begin
            @(posedge clk_in);
            #1;
        end
        check({power_down_out, osc_enable_out}, 1, "woken");
        repeat (7) @(posedge clk_in);
        check_run(1'b1, 1'b1, 1'b1);
        do_reset();
        check_run(1'b1, 1'b1, 1'b1);
        complete_run();
    end

    // watchdog sized well above the expected run of under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        $display("[FAIL] %0t run timed out", $time);
        complete_run();
    end
endmodule
`default_nettype wire
